// ### hw/timer8_pkg.sv
// Purpose: Types shared by the 8-bit timer wave control
// Assumes: Nothing beyond the register header
// Notes: State of the block is one packed struct
package timer8_pkg;

   typedef enum {KIND_PLAIN, KIND_FAST, KIND_PHASE} wave_kind_t;

   typedef struct packed {
      logic [7:0] ctrlA;
      logic modeTop;
      logic [7:0] cmpA;
      logic [7:0] cmpB;
      logic [7:0] cmpAAct;
      logic [7:0] cmpBAct;
      logic [7:0] count;
      logic down;
      logic pinA;
      logic pinB;
      logic enA;
      logic enB;
      logic ovf;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } state_t;

endpackage : timer8_pkg

// ### hw/timer8_regs.svh
// Purpose: Register offsets, field positions and constants of the 8-bit timer wave control
// Assumes: APB byte addresses, one register per aligned 32-bit word
// Notes: Definitions only
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH

`define REG_WAVE_CTRL_A 8'h30
`define REG_WAVE_CTRL_B 8'h34
`define REG_CMP_A 8'h38
`define REG_CMP_B 8'h3C
`define REG_COUNT 8'h40
`define REG_STATUS 8'h44

`define WCA_ACT_A_HI 7
`define WCA_ACT_A_LO 6
`define WCA_ACT_B_HI 5
`define WCA_ACT_B_LO 4
`define WCA_MODE_HI 1
`define WCA_MODE_LO 0
`define WCA_WRITE_MASK 8'hF3
`define WCB_TOP_BIT 3
`define STS_OVF_BIT 0
`define STS_DOWN_BIT 1

`define RESET_BYTE 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00
`define COUNT_ONE 8'h01

`define MODE_NORMAL 3'h0
`define MODE_PC_FF 3'h1
`define MODE_CTC 3'h2
`define MODE_FAST_FF 3'h3
`define MODE_PC_CMP 3'h5
`define MODE_FAST_CMP 3'h7

`define ACT_OFF 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_CLEAR 2'h2
`define ACT_SET 2'h3

`endif

// ### hw/timer8_wave_output_control.sv
// Purpose: 8-bit timer counting sequence and compare output pins A and B
// Assumes: timerTick is a one-cycle enable from a prescaler on core_clk
// Notes: Registers over APB; pins expose value and override enable
`timescale 1ns/10ps
`default_nettype none
`include "timer8_regs.svh"

module timer8_wave_output_control
   import timer8_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic timerTick,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic cmpOutAPin,
   output logic cmpOutAEn,
   output logic cmpOutBPin,
   output logic cmpOutBEn,
   output logic overflowFlag
);

   state_t s_q;
   state_t s_d;
   logic [2:0] waveModeSel;
   wave_kind_t kind;
   logic [7:0] topVal;
   logic ovfEvent;
   logic bufLoad;
   logic [1:0] nextA;
   logic [1:0] nextB;
   logic wrDone;
   logic rdStart;

   // Returns {enable, value} of one compare output for this tick
   function automatic logic [1:0] pin_next(input logic [1:0] act, input logic chanA,
      input logic [7:0] cmpV, input logic cur, input wave_kind_t k,
      input logic [7:0] cnt, input logic [7:0] top, input logic dn, input logic topBit);
      logic hit;
      logic en;
      logic val;
      hit = (cnt == cmpV);
      val = cur;
      en = (act != `ACT_OFF);
      case (k)
         KIND_PLAIN:
         begin
            if (hit)
            begin
               case (act)
                  `ACT_TOGGLE: val = ~cur;
                  `ACT_CLEAR: val = 1'b0;
                  `ACT_SET: val = 1'b1;
                  default: val = cur;
               endcase
            end
         end
         default:
         begin
            if (act == `ACT_TOGGLE)
            begin
               en = !chanA || topBit;
               if (chanA && topBit && hit)
                  val = ~cur;
            end
            else if (act[1] && k == KIND_FAST)
            begin
               if (hit && cmpV != top)
                  val = act[0];
               if (cnt == top)
                  val = ~act[0];
            end
            else if (act[1])
            begin
               if (hit && cmpV == top)
                  val = ~act[0];
               else if (hit)
                  val = dn ? ~act[0] : act[0];
            end
         end
      endcase
      return {en, val};
   endfunction : pin_next

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode

   always_comb
   begin
      waveModeSel = {s_q.modeTop, s_q.ctrlA[`WCA_MODE_HI:`WCA_MODE_LO]};
      // sequence and TOP source; reserved modes count as normal
      case (waveModeSel)
         `MODE_PC_FF, `MODE_PC_CMP: kind = KIND_PHASE;
         `MODE_FAST_FF, `MODE_FAST_CMP: kind = KIND_FAST;
         default: kind = KIND_PLAIN;
      endcase
      case (waveModeSel)
         `MODE_CTC, `MODE_PC_CMP, `MODE_FAST_CMP: topVal = s_q.cmpAAct;
         default: topVal = `COUNT_MAX;
      endcase
      case (kind)
         KIND_PHASE: ovfEvent = s_q.down && s_q.count == `COUNT_ONE;
         KIND_FAST: ovfEvent = s_q.count == topVal;
         default: ovfEvent = s_q.count == `COUNT_MAX;
      endcase
      case (kind)
         KIND_PHASE: bufLoad = timerTick && !s_q.down && s_q.count == topVal;
         KIND_FAST: bufLoad = timerTick && s_q.count == topVal;
         default: bufLoad = 1'b1;
      endcase
      nextA = pin_next(s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO], 1'b1, s_q.cmpAAct, s_q.pinA,
                       kind, s_q.count, topVal, s_q.down, s_q.modeTop);
      nextB = pin_next(s_q.ctrlA[`WCA_ACT_B_HI:`WCA_ACT_B_LO], 1'b0, s_q.cmpBAct, s_q.pinB,
                       kind, s_q.count, topVal, s_q.down, s_q.modeTop);
      wrDone = psel && penable && s_q.pready && pwrite;
      rdStart = psel && penable && !s_q.pready;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_d = s_q;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.enA = nextA[1];
      s_d.enB = nextB[1];
      if (timerTick)
      begin
         s_d.pinA = nextA[0];
         s_d.pinB = nextB[0];
         case (kind)
            KIND_PHASE:
            begin
               // dual slope, TOP held one tick
               if (!s_q.down && s_q.count == topVal)
               begin
                  s_d.down = 1'b1;
                  s_d.count = (topVal == `COUNT_BOTTOM) ? `COUNT_BOTTOM : s_q.count - `COUNT_ONE;
               end
               else if (s_q.down && s_q.count == `COUNT_BOTTOM)
               begin
                  s_d.down = 1'b0;
                  s_d.count = `COUNT_ONE;
               end
               else if (s_q.down)
                  s_d.count = s_q.count - `COUNT_ONE;
               else
                  s_d.count = s_q.count + `COUNT_ONE;
            end
            default:
            begin
               s_d.down = 1'b0;
               if (s_q.count == topVal)
                  s_d.count = `COUNT_BOTTOM;
               else
                  s_d.count = s_q.count + `COUNT_ONE;
            end
         endcase
      end
      if (bufLoad)
      begin
         s_d.cmpAAct = s_q.cmpA;
         s_d.cmpBAct = s_q.cmpB;
      end
      // Set wins over a write-one clear in the same cycle
      if (wrDone && paddr == `REG_STATUS && pwdata[`STS_OVF_BIT])
         s_d.ovf = 1'b0;
      if (timerTick && ovfEvent)
         s_d.ovf = 1'b1;
      if (rdStart)
      begin
         s_d.pready = 1'b1;
         s_d.prdata = '0;
         case (paddr)
            `REG_WAVE_CTRL_A: s_d.prdata[7:0] = s_q.ctrlA;
            `REG_WAVE_CTRL_B: s_d.prdata[`WCB_TOP_BIT] = s_q.modeTop;
            `REG_CMP_A: s_d.prdata[7:0] = s_q.cmpA;
            `REG_CMP_B: s_d.prdata[7:0] = s_q.cmpB;
            `REG_COUNT: s_d.prdata[7:0] = s_q.count;
            `REG_STATUS:
            begin
               s_d.prdata[`STS_OVF_BIT] = s_q.ovf;
               s_d.prdata[`STS_DOWN_BIT] = s_q.down;
            end
            default: s_d.pslverr = 1'b1;
         endcase
      end
      if (wrDone)
      begin
         case (paddr)
            `REG_WAVE_CTRL_A: s_d.ctrlA = pwdata[7:0] & `WCA_WRITE_MASK;
            `REG_WAVE_CTRL_B: s_d.modeTop = pwdata[`WCB_TOP_BIT];
            `REG_CMP_A: s_d.cmpA = pwdata[7:0];
            `REG_CMP_B: s_d.cmpB = pwdata[7:0];
            default: s_d.cmpB = s_d.cmpB;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign cmpOutAPin = s_q.pinA;
   assign cmpOutAEn = s_q.enA;
   assign cmpOutBPin = s_q.pinB;
   assign cmpOutBEn = s_q.enB;
   assign overflowFlag = s_q.ovf;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence sTickPlain;
      timerTick && kind == KIND_PLAIN;
   endsequence

   sequence sTickFastTop;
      timerTick && kind == KIND_FAST && s_q.count == topVal;
   endsequence

   sequence sReadCtrlA;
      psel && penable && !pwrite && !s_q.pready && paddr == `REG_WAVE_CTRL_A;
   endsequence

   sequence sTickPhase;
      timerTick && kind == KIND_PHASE;
   endsequence

   sequence sTickFastB;
      timerTick && kind == KIND_FAST && s_q.count == s_q.cmpBAct;
   endsequence

   a_pin_route_off: assert property (s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO] == `ACT_OFF
      |=> !cmpOutAEn) else $error("pin A routed with action off");
   a_plain_clear_a: assert property (sTickPlain ##0 s_q.count == s_q.cmpAAct
      ##0 s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO] == `ACT_CLEAR
      |=> !cmpOutAPin) else $error("pin A not cleared on match");
   a_plain_set_b: assert property (sTickPlain ##0 s_q.count == s_q.cmpBAct
      ##0 s_q.ctrlA[`WCA_ACT_B_HI:`WCA_ACT_B_LO] == `ACT_SET
      |=> cmpOutBPin) else $error("pin B not set on match");
   a_fast_bottom_a: assert property (sTickFastTop
      ##0 s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO] == `ACT_CLEAR
      |=> cmpOutAPin) else $error("pin A not set at bottom");
   a_phase_up_clear: assert property (timerTick && kind == KIND_PHASE && !s_q.down
      && s_q.count == s_q.cmpAAct && s_q.cmpAAct != topVal
      && s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO] == `ACT_CLEAR
      |=> !cmpOutAPin) else $error("pin A not cleared on up match");
   a_phase_turn_down: assert property (timerTick && kind == KIND_PHASE && !s_q.down
      && s_q.count == topVal && topVal != `COUNT_BOTTOM
      |=> s_q.down && s_q.count == $past(s_q.count) - `COUNT_ONE)
      else $error("phase count did not turn at top");
   a_fast_wrap_zero: assert property (sTickFastTop |=> s_q.count == `COUNT_BOTTOM)
      else $error("fast count did not wrap");
   a_normal_ovf_flag: assert property (sTickPlain ##0 s_q.count == `COUNT_MAX
      |=> overflowFlag) else $error("overflow not flagged at max");
   a_hold_no_tick: assert property (!timerTick |=> s_q.count == $past(s_q.count))
      else $error("count moved without tick");
   a_reserved_read: assert property (sReadCtrlA |=> pready && prdata[3:2] == 2'h0)
      else $error("reserved bits read nonzero");

   // Channel actions per waveform kind, buffer and flag points
   a_pin_route_b: assert property (s_q.ctrlA[`WCA_ACT_B_HI:`WCA_ACT_B_LO] == `ACT_OFF
      |=> !cmpOutBEn) else $error("pin B routed with action off");
   a_fast_inv_bottom: assert property (sTickFastTop
      ##0 s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO] == `ACT_SET
      |=> !cmpOutAPin) else $error("pin A not cleared at bottom");
   a_pwm_a_detached: assert property (kind != KIND_PLAIN && !s_q.modeTop
      && s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO] == `ACT_TOGGLE
      |=> !cmpOutAEn) else $error("pin A routed in PWM toggle without top bit");
   a_fast_clear_b: assert property (sTickFastB ##0 s_q.cmpBAct != topVal
      ##0 s_q.ctrlA[`WCA_ACT_B_HI:`WCA_ACT_B_LO] == `ACT_CLEAR
      |=> !cmpOutBPin) else $error("pin B not cleared on fast match");
   a_phase_down_b: assert property (sTickPhase ##0 s_q.down && s_q.count == s_q.cmpBAct
      && s_q.cmpBAct != topVal && s_q.ctrlA[`WCA_ACT_B_HI:`WCA_ACT_B_LO] == `ACT_CLEAR
      |=> cmpOutBPin) else $error("pin B not set on down match");
   a_fast_top_b: assert property (sTickFastTop ##0 s_q.cmpBAct == topVal
      ##0 s_q.ctrlA[`WCA_ACT_B_HI:`WCA_ACT_B_LO] == `ACT_CLEAR
      |=> cmpOutBPin) else $error("pin B not set at bottom");
   a_phase_top_a: assert property (sTickPhase ##0 !s_q.down && s_q.count == topVal
      && s_q.cmpAAct == topVal && s_q.ctrlA[`WCA_ACT_A_HI:`WCA_ACT_A_LO] == `ACT_CLEAR
      |=> cmpOutAPin) else $error("pin A not set at phase top");
   a_buf_immediate: assert property (kind == KIND_PLAIN |=> s_q.cmpAAct == $past(s_q.cmpA))
      else $error("compare A not applied at once");
   a_phase_ovf_flag: assert property (sTickPhase ##0 s_q.down && s_q.count == `COUNT_ONE
      |=> overflowFlag) else $error("overflow not flagged at bottom");

endmodule : timer8_wave_output_control
`default_nettype wire

// ### tb/tb_timer8_wave_output_control.sv
// Purpose: Self-checking bench of the 8-bit timer wave control
// Assumes: APB slave answers within a few cycles; timerTick is driven here
// Notes: Counter position is read back over APB, never modelled in the bench
`timescale 1ns/10ps
`default_nettype none
`include "timer8_regs.svh"

module tb_timer8_wave_output_control
   import timer8_pkg::*;
;
   logic core_clk, rst_n, timerTick, psel, penable, pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdq;
   logic pready, pslverr, pinA, enA, pinB, enB, ovf, err, p;
   logic [1:0] act;
   int n_mismatch, n_tests, cyc;
   logic [7:0] regList [6] = '{`REG_WAVE_CTRL_A, `REG_WAVE_CTRL_B, `REG_CMP_A,
                              `REG_CMP_B, `REG_COUNT, `REG_STATUS};

   timer8_wave_output_control i_timer8_wave_output_control (
      .core_clk(core_clk), .rst_n(rst_n), .timerTick(timerTick), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpOutAPin(pinA),
      .cmpOutAEn(enA), .cmpOutBPin(pinB), .cmpOutBEn(enB), .overflowFlag(ovf));

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task end_of_test;
   begin
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask : end_of_test

   // Ceiling well above the longest phase-correct sweeps
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
   begin
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask : chk

   // Request held until pready is seen high at a rising edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
   begin
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for the answer
      do
      begin
         @(posedge core_clk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
   begin
      apb(1'b1, a, d, q, e);
   end
   endtask : wr

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
   begin
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
   end
   endtask : rdc

   task tick;
   begin
      @(posedge core_clk);
      timerTick <= 1'b1;
      @(posedge core_clk);
      timerTick <= 1'b0;
   end
   endtask : tick

   // Ticks until count equals v in direction dn, then one more tick
   task run_to(input logic [7:0] v, input logic dn);
      logic [31:0] c;
      logic e;
      int n;
   begin
      for (n = 0; n < 600; n++)
      begin
         apb(1'b0, `REG_COUNT, 32'h0, c, e);
         if (c[7:0] === v)
         begin
            apb(1'b0, `REG_STATUS, 32'h0, c, e);
            if (c[`STS_DOWN_BIT] === dn)
               break;
         end
         tick();
      end
      if (n == 600)
      begin
         n_mismatch++;
         $display("mismatch at %0t: count %h not reached", $time, v);
      end
      tick();
      @(posedge core_clk);
   end
   endtask : run_to

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n, timerTick, psel, penable, pwrite} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      {n_mismatch, n_tests, cyc} = '0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk({pinA, pinB, enA, enB, ovf}, 32'h0);
      foreach (regList[i])
         rdc(regList[i], 32'h0);
      $display("test reset done");

      wr(`REG_WAVE_CTRL_A, 32'hFFFF_FFFF);
      rdc(`REG_WAVE_CTRL_A, 32'h0000_00F3);
      // Enables are what software pairs with the pin direction bits
      chk({enA, enB}, 32'h3);
      wr(`REG_WAVE_CTRL_A, 32'h0000_0010);
      rdc(`REG_WAVE_CTRL_A, 32'h0000_0010);
      chk({enA, enB}, 32'h1);
      apb(1'b0, 8'h50, 32'h0, rdq, err);
      chk(err, 1'b1);
      chk(rdq, 32'h0);
      $display("test registers done");

      wr(`REG_CMP_A, 32'h02);
      wr(`REG_CMP_B, 32'h05);
      for (act = 2'h3; act != 2'h0; act--)
      begin
         wr(`REG_WAVE_CTRL_A, {24'h0, act, act, 4'h0});
         run_to(8'h02, 1'b0);
         chk({enA, pinA}, {1'b1, act != 2'h2});
         run_to(8'h05, 1'b0);
         chk({enB, pinB}, {1'b1, act != 2'h2});
      end
      chk(ovf, 1'b1);
      rdc(`REG_STATUS, 32'h1);
      wr(`REG_STATUS, 32'h1);
      run_to(8'hFE, 1'b0);
      chk(ovf, 1'b0);
      run_to(8'hFF, 1'b0);
      chk(ovf, 1'b1);
      $display("test non-PWM done");

      for (act = 2'h2; act != 2'h0; act++)
      begin
         wr(`REG_WAVE_CTRL_A, {24'h0, act, act, 4'h3});
         run_to(8'h02, 1'b0);
         chk(pinA, act == 2'h3);
         run_to(8'h05, 1'b0);
         chk(pinB, act == 2'h3);
         run_to(8'h00, 1'b0);
         chk({pinA, pinB}, (act == 2'h3) ? 2'h0 : 2'h3);
      end
      wr(`REG_WAVE_CTRL_A, 32'h0000_0063);
      repeat (2) @(posedge core_clk);
      chk(enA, 1'b0);
      wr(`REG_CMP_A, 32'h10);
      wr(`REG_CMP_B, 32'h10);
      wr(`REG_WAVE_CTRL_B, 32'h08);
      run_to(8'h10, 1'b0);
      p = pinA;
      run_to(8'h0F, 1'b0);
      wr(`REG_STATUS, 32'h1);
      repeat (2) @(posedge core_clk);
      chk(ovf, 1'b0);
      run_to(8'h10, 1'b0);
      chk({ovf, pinA, enA}, {1'b1, ~p, 1'b1});
      rdc(`REG_COUNT, 32'h0);
      wr(`REG_CMP_A, 32'h08);
      run_to(8'h08, 1'b0);
      chk(pinB, 1'b1);
      run_to(8'h0C, 1'b0);
      run_to(8'h10, 1'b0);
      run_to(8'h08, 1'b0);
      rdc(`REG_COUNT, 32'h0);
      $display("test fast PWM done");

      wr(`REG_CMP_A, 32'h02);
      wr(`REG_CMP_B, 32'h05);
      wr(`REG_WAVE_CTRL_B, 32'h00);
      for (act = 2'h2; act != 2'h0; act++)
      begin
         wr(`REG_WAVE_CTRL_A, {24'h0, act, act, 4'h1});
         run_to(8'h05, 1'b1);
         chk(pinB, act == 2'h2);
         run_to(8'h02, 1'b1);
         chk(pinA, act == 2'h2);
         run_to(8'h02, 1'b0);
         chk(pinA, act == 2'h3);
         run_to(8'h05, 1'b0);
         chk(pinB, act == 2'h3);
      end
      wr(`REG_STATUS, 32'h1);
      run_to(8'h05, 1'b1);
      chk(ovf, 1'b0);
      run_to(8'h01, 1'b1);
      chk(ovf, 1'b1);
      rdc(`REG_COUNT, 32'h0);
      tick();
      rdc(`REG_COUNT, 32'h1);
      $display("test phase correct done");

      // New compare only takes hold at the first TOP, then acts at the next TOP
      wr(`REG_CMP_A, 32'hFF);
      wr(`REG_WAVE_CTRL_A, 32'h0000_0081);
      run_to(8'hFF, 1'b0);
      chk(pinA, 1'b0);
      run_to(8'hFF, 1'b0);
      chk(pinA, 1'b1);
      $display("test phase top done");

      // Clear on match: wraps at compare A, overflow only at MAX
      wr(`REG_CMP_A, 32'h04);
      wr(`REG_WAVE_CTRL_A, 32'h0000_0002);
      run_to(8'h04, 1'b0);
      rdc(`REG_COUNT, 32'h0);
      wr(`REG_STATUS, 32'h1);
      run_to(8'h04, 1'b0);
      chk(ovf, 1'b0);
      // Phase correct with TOP from compare A turns at 4
      wr(`REG_WAVE_CTRL_A, 32'h0000_0001);
      wr(`REG_WAVE_CTRL_B, 32'h08);
      run_to(8'h04, 1'b0);
      rdc(`REG_STATUS, 32'h2);
      rdc(`REG_COUNT, 32'h3);
      $display("test top from compare done");
      end_of_test();
   end
endmodule : tb_timer8_wave_output_control
`default_nettype wire
